// ---- shared/vsoc_pkg.sv ----
// Package of the velocity stop option configuration block.
// Assumes one clock domain; the dictionary port is taken as synchronous.
package vsoc_pkg;
  // Dictionary indices and subindices.
  localparam logic [15:0] IDX_QS_DECEL = 16'h604a;
  localparam logic [15:0] IDX_SPEED_FACTOR = 16'h604c;
  localparam logic [15:0] IDX_QS_OPTION = 16'h605a;
  localparam logic [15:0] IDX_SD_OPTION = 16'h605b;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;
  // Reset values.
  localparam logic [7:0] RST_SUB_COUNT = 8'h02;
  localparam logic [31:0] RST_QS_SPEED = 32'h00001388;
  localparam logic [15:0] RST_QS_TIME = 16'h0001;
  localparam logic [31:0] RST_FACTOR_NUM = 32'h00000001;
  localparam logic [31:0] RST_FACTOR_DEN = 32'h00000001;
  localparam logic [15:0] RST_QS_OPTION = 16'h0002;
  localparam logic [15:0] RST_SD_OPTION = 16'h0001;
  // Option codes.
  localparam logic [15:0] QS_IMMEDIATE = 16'h0000;
  localparam logic [15:0] QS_SLOW_SOD = 16'h0001;
  localparam logic [15:0] QS_QUICK_SOD = 16'h0002;
  localparam logic [15:0] QS_SLOW_HOLD = 16'h0005;
  localparam logic [15:0] QS_QUICK_HOLD = 16'h0006;
  localparam logic [15:0] SD_FREE = 16'h0000;
  localparam logic [15:0] SD_SLOW_SOD = 16'h0001;
  // Iterations of the serial divider, one per dividend bit.
  localparam logic [6:0] CONV_STEPS = 7'h40;

  // Ramp that the ramp generator is told to use.
  typedef enum logic [1:0] {
    VSOC_RAMP_NONE = 2'b00,
    VSOC_RAMP_SLOW = 2'b01,
    VSOC_RAMP_QUICK = 2'b10,
    VSOC_RAMP_IMMED = 2'b11
  } vsoc_ramp_e;
  // Phase of the stop reaction.
  typedef enum logic [1:0] {
    VSOC_PH_IDLE = 2'b00,
    VSOC_PH_BRAKE = 2'b01,
    VSOC_PH_HOLD = 2'b10,
    VSOC_PH_FREE = 2'b11
  } vsoc_phase_e;

  // Dictionary request from the fieldbus side.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] wdata;
  } vsoc_req_s;
  // Dictionary answer.
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } vsoc_rsp_s;
  // Events and levels from the power state machine and ramps.
  typedef struct packed {
    logic qs_enter;
    logic shutdown;
    logic op_enable;
    logic vel_mode;
    logic stopped;
  } vsoc_drive_s;
  // Reaction commands to the power state machine and ramps.
  typedef struct packed {
    vsoc_ramp_e ramp;
    logic drive_block;
    logic to_sod;
    logic hold;
    logic use_qs_record;
  } vsoc_react_s;
endpackage

// ---- core/vsoc_speed_conv.sv ----
// Serial converter from internal speed to revolutions per minute.
// Assumes start is only pulsed while busy is low.
`timescale 1ns/1ps
module vsoc_speed_conv (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Conversion request.
  input wire logic start_i,
  input wire logic [31:0] speed_i,
  input wire logic [31:0] num_i,
  input wire logic [31:0] den_i,
  // Result.
  output logic busy_o,
  output logic done_o,
  output logic div_zero_o,
  output logic [31:0] rpm_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic dz;
    logic neg;
    logic [6:0] cnt;
    logic [63:0] quo;
    logic [32:0] rem;
    logic [31:0] dmag;
    logic [31:0] rpm;
  } vsoc_conv_s;
  vsoc_conv_s s, next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Multiply first, then restoring division, so no precision is lost early.
  always_comb begin
    logic [63:0] prod;
    logic [32:0] rsh;
    prod = 64'($signed(speed_i) * $signed(num_i));
    rsh = {s.rem[31:0], s.quo[63]};
    next_s = s;
    next_s.done = 1'b0;
    if (start_i && !s.busy) begin
      next_s.neg = prod[63] ^ den_i[31];
      next_s.quo = prod[63] ? 64'(-prod) : prod;
      next_s.dmag = den_i[31] ? 32'(-den_i) : den_i;
      next_s.rem = 33'h000000000;
      next_s.cnt = vsoc_pkg::CONV_STEPS;
      next_s.dz = (den_i == 32'h00000000);
      next_s.busy = (den_i != 32'h00000000);
      next_s.done = (den_i == 32'h00000000);
    end else if (s.busy) begin
      next_s.quo = {s.quo[62:0], 1'b0};
      if (rsh >= {1'b0, s.dmag}) begin
        next_s.rem = 33'(rsh - {1'b0, s.dmag});
        next_s.quo[0] = 1'b1;
      end else begin
        next_s.rem = rsh;
      end
      next_s.cnt = 7'(s.cnt - 7'h01);
      if (s.cnt == 7'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.rpm = s.neg ? 32'(-next_s.quo[31:0]) : next_s.quo[31:0];
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;
  assign div_zero_o = s.dz;
  assign rpm_o = s.rpm;

  // A started conversion ends within 65 cycles, one more than the divider length.
  conv_bounded_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o) |-> ##[1:65] done_o)
    else $error("conversion did not finish in time");
endmodule // vsoc_speed_conv

// ---- core/vsoc_config.sv ----
// Stop configuration objects and stop reaction sequencer.
// Assumes dictionary requests and drive events are synchronous to clk_i.
`timescale 1ns/1ps
//
// Contract
// - Quick stop in velocity mode uses record; the code uses it only with the quick ramp (codes 2/6).
// - Deceleration is speed term over time term.
// - Velocity speeds use the unit factor.
// - Convert speed: times numerator, divide denominator.
// - Quick stop entry runs quick stop option.
// - Code 0: immediate stop, then switch-on-disabled.
// - Codes 1/2: slow/quick ramp, then disabled.
// - Codes 5/6: ramp, hold energized, reenable allowed.
// - Shutdown transition runs shutdown option.
// - Shutdown code 0: drive blocked, free turning.
// - Shutdown code 1: slow ramp, then disabled.
module vsoc_config (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Dictionary port.
  input wire vsoc_pkg::vsoc_req_s req_i,
  output vsoc_pkg::vsoc_rsp_s rsp_o,
  // Power state machine and ramp generator.
  input wire vsoc_pkg::vsoc_drive_s drive_i,
  output vsoc_pkg::vsoc_react_s react_o,
  // Quick stop deceleration record.
  output logic [31:0] qs_speed_change_o,
  output logic [15:0] qs_time_change_o,
  // Speed conversion.
  input wire logic conv_start_i,
  input wire logic [31:0] conv_speed_i,
  output logic conv_busy_o,
  output logic conv_done_o,
  output logic conv_div_zero_o,
  output logic [31:0] conv_rpm_o
);
  // All state of the block.
  typedef struct packed {
    logic [31:0] speed_change_term;
    logic [15:0] time_change_term;
    logic [31:0] factor_num;
    logic [31:0] factor_den;
    logic [15:0] qs_option;
    logic [15:0] sd_option;
    logic sod_after;
    vsoc_pkg::vsoc_phase_e phase;
    vsoc_pkg::vsoc_rsp_s rsp;
    vsoc_pkg::vsoc_react_s react;
  } vsoc_cfg_s;
  vsoc_cfg_s s, next_s;

  // Legal quick stop codes; anything else is reserved.
  function automatic logic qs_code_ok(input logic [15:0] c);
    return c == vsoc_pkg::QS_IMMEDIATE || c == vsoc_pkg::QS_SLOW_SOD ||
           c == vsoc_pkg::QS_QUICK_SOD || c == vsoc_pkg::QS_SLOW_HOLD ||
           c == vsoc_pkg::QS_QUICK_HOLD;
  endfunction

  // Legal shutdown codes.
  function automatic logic sd_code_ok(input logic [15:0] c);
    return c == vsoc_pkg::SD_FREE || c == vsoc_pkg::SD_SLOW_SOD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Dictionary access and reaction sequencing in one next-state process.
  always_comb begin
    logic hit;
    logic ok;
    logic [31:0] rd;
    hit = 1'b1;
    ok = 1'b1;
    rd = 32'h00000000;
    next_s = s;
    next_s.rsp.ack = req_i.valid;
    next_s.rsp.err = 1'b0;
    next_s.rsp.rdata = 32'h00000000;
    next_s.react.to_sod = 1'b0;
    // Narrow objects read back zero-extended in the low bits.
    unique case ({req_i.index, req_i.subindex})
      {vsoc_pkg::IDX_QS_DECEL, vsoc_pkg::SUB_COUNT},
      {vsoc_pkg::IDX_SPEED_FACTOR, vsoc_pkg::SUB_COUNT}: begin
        rd = {24'h000000, vsoc_pkg::RST_SUB_COUNT};
        ok = !req_i.write;
      end
      {vsoc_pkg::IDX_QS_DECEL, vsoc_pkg::SUB_FIRST}: begin
        rd = s.speed_change_term;
      end
      {vsoc_pkg::IDX_QS_DECEL, vsoc_pkg::SUB_SECOND}: begin
        rd = {16'h0000, s.time_change_term};
      end
      {vsoc_pkg::IDX_SPEED_FACTOR, vsoc_pkg::SUB_FIRST}: begin
        rd = s.factor_num;
      end
      {vsoc_pkg::IDX_SPEED_FACTOR, vsoc_pkg::SUB_SECOND}: begin
        rd = s.factor_den;
      end
      {vsoc_pkg::IDX_QS_OPTION, vsoc_pkg::SUB_COUNT}: begin
        rd = {16'h0000, s.qs_option};
        ok = !req_i.write || qs_code_ok(req_i.wdata[15:0]);
      end
      {vsoc_pkg::IDX_SD_OPTION, vsoc_pkg::SUB_COUNT}: begin
        rd = {16'h0000, s.sd_option};
        ok = !req_i.write || sd_code_ok(req_i.wdata[15:0]);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (req_i.valid) begin
      next_s.rsp.err = !(hit && ok);
      next_s.rsp.rdata = (hit && !req_i.write) ? rd : 32'h00000000;
    end
    // Commit a write only when it was answered without error.
    if (req_i.valid && req_i.write && hit && ok) begin
      unique case ({req_i.index, req_i.subindex})
        {vsoc_pkg::IDX_QS_DECEL, vsoc_pkg::SUB_FIRST}: next_s.speed_change_term = req_i.wdata;
        {vsoc_pkg::IDX_QS_DECEL, vsoc_pkg::SUB_SECOND}: next_s.time_change_term = req_i.wdata[15:0];
        {vsoc_pkg::IDX_SPEED_FACTOR, vsoc_pkg::SUB_FIRST}: next_s.factor_num = req_i.wdata;
        {vsoc_pkg::IDX_SPEED_FACTOR, vsoc_pkg::SUB_SECOND}: next_s.factor_den = req_i.wdata;
        {vsoc_pkg::IDX_QS_OPTION, vsoc_pkg::SUB_COUNT}: next_s.qs_option = req_i.wdata[15:0];
        {vsoc_pkg::IDX_SD_OPTION, vsoc_pkg::SUB_COUNT}: next_s.sd_option = req_i.wdata[15:0];
        default: begin
        end
      endcase
    end
    // Reaction phases; a quick stop entry beats a shutdown in the same cycle.
    unique case (s.phase)
      vsoc_pkg::VSOC_PH_IDLE: begin
        if (drive_i.qs_enter) begin
          next_s.phase = vsoc_pkg::VSOC_PH_BRAKE;
          next_s.sod_after = !(s.qs_option == vsoc_pkg::QS_SLOW_HOLD ||
                               s.qs_option == vsoc_pkg::QS_QUICK_HOLD);
          if (s.qs_option == vsoc_pkg::QS_IMMEDIATE) begin
            next_s.react.ramp = vsoc_pkg::VSOC_RAMP_IMMED;
          end else if (s.qs_option == vsoc_pkg::QS_SLOW_SOD || s.qs_option == vsoc_pkg::QS_SLOW_HOLD) begin
            next_s.react.ramp = vsoc_pkg::VSOC_RAMP_SLOW;
          end else begin
            next_s.react.ramp = vsoc_pkg::VSOC_RAMP_QUICK;
          end
        end else if (drive_i.shutdown) begin
          if (s.sd_option == vsoc_pkg::SD_FREE) begin
            next_s.phase = vsoc_pkg::VSOC_PH_FREE;
          end else begin
            next_s.phase = vsoc_pkg::VSOC_PH_BRAKE;
            next_s.sod_after = 1'b1;
            next_s.react.ramp = vsoc_pkg::VSOC_RAMP_SLOW;
          end
        end
      end
      vsoc_pkg::VSOC_PH_BRAKE: begin
        // Braking lasts until the ramp generator reports standstill.
        if (drive_i.stopped) begin
          next_s.react.ramp = vsoc_pkg::VSOC_RAMP_NONE;
          next_s.react.to_sod = s.sod_after;
          next_s.phase = s.sod_after ? vsoc_pkg::VSOC_PH_IDLE : vsoc_pkg::VSOC_PH_HOLD;
        end
      end
      vsoc_pkg::VSOC_PH_HOLD, vsoc_pkg::VSOC_PH_FREE: begin
        // Held or free-wheeling until operation is enabled again.
        if (drive_i.op_enable) begin
          next_s.phase = vsoc_pkg::VSOC_PH_IDLE;
        end
      end
    endcase
    next_s.react.hold = (next_s.phase == vsoc_pkg::VSOC_PH_HOLD);
    next_s.react.drive_block = (next_s.phase == vsoc_pkg::VSOC_PH_FREE);
    // The record is only meaningful to the ramp while in velocity mode.
    next_s.react.use_qs_record = (next_s.react.ramp == vsoc_pkg::VSOC_RAMP_QUICK) && drive_i.vel_mode;
  end

  // Register the whole state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.speed_change_term <= vsoc_pkg::RST_QS_SPEED;
      s.time_change_term <= vsoc_pkg::RST_QS_TIME;
      s.factor_num <= vsoc_pkg::RST_FACTOR_NUM;
      s.factor_den <= vsoc_pkg::RST_FACTOR_DEN;
      s.qs_option <= vsoc_pkg::RST_QS_OPTION;
      s.sd_option <= vsoc_pkg::RST_SD_OPTION;
      s.sod_after <= 1'b0;
      s.phase <= vsoc_pkg::VSOC_PH_IDLE;
      s.rsp <= '0;
      s.react <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rsp_o = s.rsp;
  assign react_o = s.react;
  assign qs_speed_change_o = s.speed_change_term;
  assign qs_time_change_o = s.time_change_term;

  ////////////////////////////////////////////////////////////////////////////
  // Converter applies the unit factor to speeds.
  vsoc_speed_conv u_conv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(conv_start_i),
    .speed_i(conv_speed_i),
    .num_i(s.factor_num),
    .den_i(s.factor_den),
    .busy_o(conv_busy_o),
    .done_o(conv_done_o),
    .div_zero_o(conv_div_zero_o),
    .rpm_o(conv_rpm_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Quick stop entry from idle with a given code.
  sequence qs_entry(logic [15:0] code);
    s.phase == vsoc_pkg::VSOC_PH_IDLE && drive_i.qs_enter && s.qs_option == code;
  endsequence
  // Braking finished with standstill.
  sequence brake_done;
    s.phase == vsoc_pkg::VSOC_PH_BRAKE && drive_i.stopped;
  endsequence

  qs_record_use_a: assert property (
    react_o.use_qs_record |-> react_o.ramp == vsoc_pkg::VSOC_RAMP_QUICK && $past(drive_i.vel_mode))
    else $error("quick stop record used outside quick ramp");
  decel_write_a: assert property (
    req_i.valid && req_i.write && req_i.index == vsoc_pkg::IDX_QS_DECEL && req_i.subindex == vsoc_pkg::SUB_FIRST
    |=> qs_speed_change_o == $past(req_i.wdata) && !rsp_o.err)
    else $error("speed change term not stored");
  qs_reaction_a: assert property (
    (s.phase == vsoc_pkg::VSOC_PH_IDLE && drive_i.qs_enter) |=> s.phase == vsoc_pkg::VSOC_PH_BRAKE)
    else $error("quick stop entry ignored");
  immediate_stop_a: assert property (
    qs_entry(vsoc_pkg::QS_IMMEDIATE) |=> react_o.ramp == vsoc_pkg::VSOC_RAMP_IMMED)
    else $error("code zero did not stop immediately");
  slow_then_sod_a: assert property (
    qs_entry(vsoc_pkg::QS_SLOW_SOD) ##1 (!drive_i.stopped)[*2] ##1 brake_done
    |=> react_o.to_sod && react_o.ramp == vsoc_pkg::VSOC_RAMP_NONE)
    else $error("slow ramp did not end in switch on disabled");
  // Hold stands after braking; re-enabling operation may end it from the next cycle on.
  hold_energized_a: assert property (
    qs_entry(vsoc_pkg::QS_QUICK_HOLD) ##1 brake_done
    |=> (react_o.hold && !react_o.to_sod) ##1 (react_o.hold || $past(drive_i.op_enable)))
    else $error("hold code did not keep quick stop active");
  shutdown_free_a: assert property (
    s.phase == vsoc_pkg::VSOC_PH_IDLE && !drive_i.qs_enter && drive_i.shutdown && s.sd_option == vsoc_pkg::SD_FREE
    |=> react_o.drive_block && react_o.ramp == vsoc_pkg::VSOC_RAMP_NONE)
    else $error("shutdown code zero did not block the drive");
  shutdown_slow_a: assert property (
    s.phase == vsoc_pkg::VSOC_PH_IDLE && !drive_i.qs_enter && drive_i.shutdown && s.sd_option == vsoc_pkg::SD_SLOW_SOD
    |=> react_o.ramp == vsoc_pkg::VSOC_RAMP_SLOW)
    else $error("shutdown code one did not brake slowly");
  reserved_refused_a: assert property (
    req_i.valid && req_i.write && req_i.index == vsoc_pkg::IDX_QS_OPTION && req_i.subindex == vsoc_pkg::SUB_COUNT
    && !qs_code_ok(req_i.wdata[15:0]) |=> rsp_o.err && $stable(s.qs_option))
    else $error("reserved quick stop code accepted");
endmodule // vsoc_config

// ---- tb/vsoc_master_model.sv ----
// Fieldbus master model: issues dictionary reads and writes one at a time.
// Assumes the block takes a request at the edge that sees valid and acks in the next cycle.
`timescale 1ns/1ps
module vsoc_master_model (
  // Clock.
  input wire logic clk_i,
  // Dictionary port.
  output vsoc_pkg::vsoc_req_s req_o,
  input wire vsoc_pkg::vsoc_rsp_s rsp_i
);
  initial begin
    req_o = '0;
  end

  // One transfer; the answer is taken in the cycle after the request edge.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
      output logic ack, output logic err, output logic [31:0] rd);
    @(posedge clk_i);
    #1;
    req_o = {1'b1, wr, idx, sub, wd};
    @(posedge clk_i);
    #1;
    ack = rsp_i.ack;
    err = rsp_i.err;
    rd = rsp_i.rdata;
    // Released fields carry inverted data, so a design reading stale fields is caught.
    req_o = {1'b0, ~wr, ~idx, ~sub, ~wd};
  endtask
endmodule // vsoc_master_model

// ---- tb/tb_velocity_stop_option_config.sv ----
// Self-checking bench of the stop configuration block.
// Assumes the master model for dictionary access; drive events come from this bench.
`timescale 1ns/1ps
module tb_velocity_stop_option_config;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  vsoc_pkg::vsoc_req_s req;
  vsoc_pkg::vsoc_rsp_s rsp;
  vsoc_pkg::vsoc_drive_s drv = '0;
  vsoc_pkg::vsoc_react_s react;
  logic [31:0] qs_speed;
  logic [15:0] qs_time;
  logic conv_start = 1'b0;
  logic [31:0] conv_speed = 32'h0;
  logic busy, done, dz;
  logic [31:0] rpm;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] oq, os;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz; the ceiling bounds a hung handshake.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      $display("ERROR at %0t: timeout", $time);
      wrap_up();
    end
  end

  vsoc_master_model i_master (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
  vsoc_config i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp), .drive_i(drv), .react_o(react),
    .qs_speed_change_o(qs_speed), .qs_time_change_o(qs_time), .conv_start_i(conv_start),
    .conv_speed_i(conv_speed), .conv_busy_o(busy), .conv_done_o(done), .conv_div_zero_o(dz), .conv_rpm_o(rpm));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Dictionary access with the expected answer.
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
      input logic exp_err);
    logic ack, err;
    logic [31:0] rd;
    i_master.xfer(wr, idx, sub, d, ack, err, rd);
    chk(ack, 1, "ack");
    chk(err, exp_err, "err");
    if (!wr && !exp_err) begin
      chk(rd, d, "rdata");
    end
  endtask

  // One stop reaction: event, brake, standstill, then back to operation enabled.
  // Standstill is reported after brake_cycles extra cycles, so a long brake is exercised too.
  task automatic stop_run(input logic qs, input logic vm, input logic [1:0] ramp, input logic sod,
      input logic hold, input logic blk, input int brake_cycles);
    drv.vel_mode = vm;
    @(posedge clk_i);
    #1;
    drv.qs_enter = qs;
    drv.shutdown = ~qs;
    @(posedge clk_i);
    #1;
    drv.qs_enter = 1'b0;
    drv.shutdown = 1'b0;
    chk(react.ramp, ramp, "ramp");
    chk(react.drive_block, blk, "drive_block");
    chk(react.use_qs_record, qs && vm && ramp == vsoc_pkg::VSOC_RAMP_QUICK, "use_qs_record");
    repeat (brake_cycles) begin
      @(posedge clk_i);
      #1;
    end
    chk(react.ramp, ramp, "ramp kept");
    drv.stopped = 1'b1;
    @(posedge clk_i);
    #1;
    drv.stopped = 1'b0;
    chk(react.drive_block, blk, "block kept");
    if (!blk) begin
      chk(react.ramp, vsoc_pkg::VSOC_RAMP_NONE, "ramp end");
      chk(react.to_sod, sod, "to_sod");
      chk(react.hold, hold, "hold");
    end
    @(posedge clk_i);
    #1;
    chk(react.hold, hold, "hold kept");
    chk(react.drive_block, blk, "block still");
    drv.op_enable = 1'b1;
    @(posedge clk_i);
    #1;
    drv.op_enable = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({react.hold, react.drive_block, react.to_sod}, 0, "released");
  endtask

  // One conversion: done must come after the fixed latency.
  task automatic conv(input logic [31:0] s, input logic [31:0] exp, input logic exp_dz);
    int n;
    @(posedge clk_i);
    #1;
    conv_start = 1'b1;
    conv_speed = s;
    @(posedge clk_i);
    #1;
    conv_start = 1'b0;
    conv_speed = ~s;
    chk(busy, !exp_dz, "busy");
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n, exp_dz ? 1 : 65, "latency");
    chk(busy, 0, "busy end");
    chk(dz, exp_dz, "div_zero");
    if (!exp_dz) begin
      chk(rpm, exp, "rpm");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    // Reset values of every object.
    acc(0, 16'h604a, 8'h00, 32'h02, 0);
    acc(0, 16'h604a, 8'h01, 32'h00001388, 0);
    acc(0, 16'h604a, 8'h02, 32'h0001, 0);
    acc(0, 16'h604c, 8'h00, 32'h02, 0);
    acc(0, 16'h604c, 8'h01, 32'h1, 0);
    acc(0, 16'h604c, 8'h02, 32'h1, 0);
    acc(0, 16'h605a, 8'h00, 32'h0002, 0);
    acc(0, 16'h605b, 8'h00, 32'h0001, 0);
    $display("test reset done");
    // Record write; the 16-bit time term ignores the upper wdata bits.
    acc(1, 16'h604a, 8'h01, 32'h0000abcd, 0);
    acc(1, 16'h604a, 8'h02, 32'hffff0010, 0);
    acc(0, 16'h604a, 8'h02, 32'h0010, 0);
    chk(qs_speed, 32'h0000abcd, "speed term");
    chk(qs_time, 16'h0010, "time term");
    acc(1, 16'h604c, 8'h00, 32'h5, 1);
    acc(0, 16'h6049, 8'h01, 32'h0, 1);
    acc(0, 16'h604a, 8'h03, 32'h0, 1);
    $display("test record done");
    // Every code 0 to 7; reserved ones are refused and the setting is kept.
    oq = 16'h0002;
    os = 16'h0001;
    for (int c = 0; c < 8; c++) begin
      acc(1, 16'h605a, 8'h00, 32'(c), !(c inside {0, 1, 2, 5, 6}));
      oq = (c inside {0, 1, 2, 5, 6}) ? 16'(c) : oq;
      acc(0, 16'h605a, 8'h00, {16'h0000, oq}, 0);
      acc(1, 16'h605b, 8'h00, 32'(c), c > 1);
      os = (c < 2) ? 16'(c) : os;
      acc(0, 16'h605b, 8'h00, {16'h0000, os}, 0);
    end
    $display("test codes done");
    // Quick stop reaction for each defined code, then both shutdown codes.
    for (int i = 0; i < 5; i++) begin
      acc(1, 16'h605a, 8'h00, 32'(i < 3 ? i : i + 2), 0);
      stop_run(1, 1, i == 0 ? 2'b11 : (i % 2 == 1 ? 2'b01 : 2'b10), i < 3, i > 2, 0, i == 1 ? 2 : 0);
    end
    acc(1, 16'h605a, 0, 2, 0);
    stop_run(1, 0, 2'b10, 1, 0, 0, 0);
    acc(1, 16'h605b, 0, 1, 0);
    stop_run(0, 1, 2'b01, 1, 0, 0, 0);
    acc(1, 16'h605b, 0, 0, 0);
    stop_run(0, 1, 2'b00, 0, 0, 1, 0);
    $display("test reactions done");
    // Conversion to revolutions per minute, truncating toward zero.
    acc(1, 16'h604c, 8'h01, 32'd60, 0);
    conv(32'd25, 32'd1500, 0);
    acc(1, 16'h604c, 8'h01, 32'd3, 0);
    acc(1, 16'h604c, 8'h02, 32'd2, 0);
    conv(-32'sd7, -32'sd10, 0);
    acc(1, 16'h604c, 8'h02, 32'd0, 0);
    conv(32'd9, 32'd0, 1);
    $display("test convert done");
    wrap_up();
  end
endmodule // tb_velocity_stop_option_config
